/* File: bench/gsh_host_model.sv */
/*
  host model: bus master that drives the shared pins as I2C or SPI.
  assumes the bench resolves sda with a pull-up and calls the tasks.
*/
`timescale 1ns/100ps
module gsh_host_model (
  input wire logic sys_clk_in, // system clock
  input wire logic sda_in, // resolved sda level
  input wire logic miso_in, // miso pin level
  output logic scl_out, // scl / sclk pin
  output logic sda_out, // 1 releases sda, mosi level
  output logic chip_select_low_out // chip select pin
);
  // idle bus: released lines, chip select high
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    chip_select_low_out = 1'b1;
  end
  // wait falling edges, all pin changes land there
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : tick
  // start or repeated start, sda falls while scl high
  task automatic start();
    sda_out = 1'b1;
    tick(10);
    scl_out = 1'b1;
    tick(10);
    sda_out = 1'b0;
    tick(10);
    scl_out = 1'b0;
    tick(2);
  endtask : start
  // stop, sda rises while scl high
  task automatic stop();
    sda_out = 1'b0;
    tick(10);
    scl_out = 1'b1;
    tick(10);
    sda_out = 1'b1;
    tick(10);
  endtask : stop
  // one clock pulse; data set while scl low, sampled mid-high
  task automatic bit_x(input logic b, output logic r);
    sda_out = b;
    tick(10);
    scl_out = 1'b1;
    tick(5);
    r = sda_in;
    tick(5);
    scl_out = 1'b0;
    tick(2); // keeps sda change apart from scl fall
  endtask : bit_x
  // byte out msb first, then ack bit from slave
  task automatic byte_w(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : byte_w
  // byte in, then ack (0) or nack (1) for the last byte
  task automatic byte_r(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(last, r);
  endtask : byte_r
  // spi byte, mosi set while sclk low, both sides msb first
  task automatic spi_x(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      sda_out = b[i];
      tick(6);
      r[i] = miso_in;
      scl_out = 1'b1;
      tick(6);
      scl_out = 1'b0;
    end
  endtask : spi_x
endmodule : gsh_host_model

/* File: bench/tb_gsh_host_if.sv */
/*
  testbench of the host front end: validity code, I2C write, read and
  refusal, SPI selection. assumes a register map answering addr ^ 5a.
*/
`timescale 1ns/100ps
module tb_gsh_host_if;
  logic sys_clk;
  logic rst_n;
  logic first_life;
  logic signals_bad;
  logic strap;
  logic scl, host_sda, cs_n, sda_oe, miso, miso_oe, reg_wr, reg_rd, start_done, spi_mode;
  logic [7:0] reg_addr, reg_wdata;
  logic [1:0] validity;
  logic [7:0] wa[$];
  logic [7:0] wd[$];
  logic [7:0] ra[$];
  int miscompares = 0;
  int cmp_count = 0;
  // pins: open-drain sda with pull-up, miso pulled to the strap level
  wire sda_wire = host_sda & ~sda_oe;
  wire miso_pin = miso_oe ? miso : strap;
  wire [7:0] rdata = reg_addr ^ 8'h5a;
  always #10 sys_clk = ~sys_clk;
  gsh_host_if #(.WARMUP_CYC(38'd200), .STARTUP_CYC(38'd1000)) i_dut (
    .sys_clk_in(sys_clk),
    .rst_n_in(rst_n),
    .sclk_in(scl),
    .sda_mosi_in(sda_wire),
    .chip_select_low_in(cs_n),
    .miso_addr_in(miso_pin),
    .first_life_in(first_life),
    .signals_bad_in(signals_bad),
    .reg_rdata_in(rdata),
    .sda_oe_out(sda_oe),
    .miso_out(miso),
    .miso_oe_out(miso_oe),
    .reg_addr_out(reg_addr),
    .reg_wdata_out(reg_wdata),
    .reg_wr_out(reg_wr),
    .reg_rd_out(reg_rd),
    .validity_out(validity),
    .start_done_out(start_done),
    .spi_mode_out(spi_mode)
  );
  gsh_host_model i_host (
    .sys_clk_in(sys_clk),
    .sda_in(sda_wire),
    .miso_in(miso_pin),
    .scl_out(scl),
    .sda_out(host_sda),
    .chip_select_low_out(cs_n)
  );
  // record every write and read strobe, away from the launching edge
  always @(negedge sys_clk)
  begin
    if (reg_wr === 1'b1)
    begin
      wa.push_back(reg_addr);
      wd.push_back(reg_wdata);
    end
    if (reg_rd === 1'b1)
    begin
      ra.push_back(reg_addr);
    end
  end
  // compare and report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic end_sim();
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // reset for 3 cycles, then let the strap settle
  task automatic do_reset(input logic life);
    @(negedge sys_clk);
    rst_n = 1'b0;
    first_life = life;
    i_host.tick(3);
    rst_n = 1'b1;
    i_host.tick(10);
  endtask : do_reset
  // warm-up, invalid and start-up codes over time
  task automatic t_validity();
    do_reset(1'b0);
    check(validity, 8'h01);
    i_host.tick(220);
    check(validity, 8'h00);
    signals_bad = 1'b1;
    i_host.tick(2);
    check(validity, 8'h03);
    signals_bad = 1'b0;
    do_reset(1'b1);
    check(validity, 8'h02);
    check(start_done, 8'h00);
    i_host.tick(1020);
    check(validity, 8'h00);
    check(start_done, 8'h01);
  endtask : t_validity
  // burst write of two bytes at 0x10
  task automatic t_write();
    logic a0, a1, a2, a3;
    wa.delete();
    wd.delete();
    i_host.start();
    i_host.byte_w(8'ha4, a0);
    i_host.byte_w(8'h10, a1);
    i_host.byte_w(8'h11, a2);
    i_host.byte_w(8'h22, a3);
    i_host.stop();
    check({a0, a1, a2, a3}, 8'h0f);
    check(wa.size(), 8'h02);
    check(wa[0], 8'h10);
    check(wd[0], 8'h11);
    check(wa[1], 8'h11);
    check(wd[1], 8'h22);
  endtask : t_write
  // other address, general call, 10-bit prefix: all refused
  task automatic t_refuse();
    logic [7:0] tbl[3] = '{8'ha6, 8'h00, 8'hf0};
    logic ack, ack2;
    wa.delete();
    foreach (tbl[i])
    begin
      i_host.start();
      i_host.byte_w(tbl[i], ack);
      i_host.byte_w(8'h10, ack2);
      i_host.stop();
      check(ack | ack2, 8'h00);
    end
    check(wa.size(), 8'h00);
  endtask : t_refuse
  // read two bytes from 0x1f across the status register
  task automatic t_read();
    logic a0, a1, a2;
    logic [7:0] b0, b1;
    ra.delete();
    i_host.start();
    i_host.byte_w(8'ha4, a0);
    i_host.byte_w(8'h1f, a1);
    i_host.start();
    i_host.byte_w(8'ha5, a2);
    i_host.byte_r(1'b0, b0);
    i_host.byte_r(1'b1, b1);
    i_host.stop();
    check({a0, a1, a2}, 8'h07);
    check(b0, 8'h45);
    check(b1, 8'h00);
    check(ra.size(), 8'h02);
    check(ra[1], 8'h20);
  endtask : t_read
  // strap high at reset moves the address to 0x53
  task automatic t_strap();
    logic a0, a1, a2;
    strap = 1'b1;
    do_reset(1'b0);
    i_host.start();
    i_host.byte_w(8'ha4, a0);
    i_host.stop();
    i_host.start();
    i_host.byte_w(8'ha6, a1);
    i_host.byte_w(8'h30, a2);
    i_host.stop();
    check({a0, a1, a2}, 8'h03);
    strap = 1'b0;
    do_reset(1'b0);
  endtask : t_strap
  // spi write and read, then I2C must stay ignored
  task automatic t_spi();
    logic [7:0] r;
    logic ack;
    wa.delete();
    wd.delete();
    i_host.scl_out = 1'b0;
    i_host.tick(5);
    i_host.chip_select_low_out = 1'b0;
    i_host.tick(6);
    check(miso_oe, 8'h01);
    i_host.spi_x(8'h0a, r);
    i_host.spi_x(8'h77, r);
    i_host.chip_select_low_out = 1'b1;
    i_host.tick(6);
    check(spi_mode, 8'h01);
    check(miso_oe, 8'h00);
    check(wa[0], 8'h05);
    check(wd[0], 8'h77);
    i_host.chip_select_low_out = 1'b0;
    i_host.tick(6);
    i_host.spi_x(8'h0b, r);
    i_host.spi_x(8'h00, r);
    i_host.chip_select_low_out = 1'b1;
    i_host.tick(6);
    check(r, 8'h5f);
    i_host.start();
    i_host.byte_w(8'ha4, ack);
    i_host.stop();
    check(ack, 8'h00);
    check(spi_mode, 8'h01);
  endtask : t_spi
  // main sequence
  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    first_life = 1'b0;
    signals_bad = 1'b0;
    strap = 1'b0;
    t_validity();
    t_write();
    t_refuse();
    t_read();
    t_strap();
    t_spi();
    end_sim();
  end
  // hang guard
  initial
  begin
    #1000000;
    miscompares++;
    end_sim();
  end
endmodule : tb_gsh_host_if

/* File: design/gsh_host_if.sv */
/*
  host front end of the gas sensor: shared-pin I2C/SPI slave, register
  port with auto-increment, validity code generator.
  assumes the register map sits outside on the same clock and answers
  reg_rdata_in combinationally for reg_addr_out while reg_rd_out is high.
*/
`timescale 1ns/100ps
`include "gsh_params.svh"
module gsh_host_if #(
  parameter logic [`GSH_UP_W-1:0] WARMUP_CYC =
    `GSH_UP_W'(64'(`GSH_WARMUP_S) * 64'(`GSH_CLK_HZ)),
  parameter logic [`GSH_UP_W-1:0] STARTUP_CYC =
    `GSH_UP_W'(64'(`GSH_STARTUP_S) * 64'(`GSH_CLK_HZ))
) (
  input wire logic sys_clk_in, // system clock
  input wire logic rst_n_in, // power-on reset
  input wire logic sclk_in, // shared scl / spi clock pin
  input wire logic sda_mosi_in, // shared sda / mosi pin
  input wire logic chip_select_low_in, // chip select pin
  input wire logic miso_addr_in, // miso / address strap pin
  input wire logic first_life_in, // never completed start-up
  input wire logic signals_bad_in, // outputs implausible
  input wire logic [7:0] reg_rdata_in, // register map read data
  output logic sda_oe_out, // pull sda low
  output logic miso_out, // spi data out
  output logic miso_oe_out, // drive miso pin
  output logic [7:0] reg_addr_out, // register address
  output logic [7:0] reg_wdata_out, // register write data
  output logic reg_wr_out, // write strobe
  output logic reg_rd_out, // read strobe
  output logic [1:0] validity_out, // validity code
  output logic start_done_out, // start-up complete
  output logic spi_mode_out // spi selected
);

  gsh_pkg::gsh_regs_t s_r;
  gsh_pkg::gsh_regs_t s_nxt;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic spi;
  logic [7:0] inb;
  logic [7:0] rsel;
  logic [6:0] my_addr;

  // bus events from the synchronised pins
  assign rise = s_r.scl2 & ~s_r.scl3;
  assign fall = ~s_r.scl2 & s_r.scl3;
  assign start_c = s_r.scl2 & s_r.scl3 & ~s_r.sda2 & s_r.sda3;
  assign stop_c = s_r.scl2 & s_r.scl3 & s_r.sda2 & ~s_r.sda3;
  assign spi = s_r.spi_mode | (s_r.strap_done & ~s_r.cs2);
  assign inb = {s_r.shreg[6:0], s_r.sda2};
  assign my_addr = {`GSH_ADDR_HI, s_r.addr_lsb};
  // status lives inside, all else from the shared map
  assign rsel = (s_r.addr == `GSH_STATUS_ADDR) ? {6'h00, s_r.validity}
    : reg_rdata_in;

  // next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.wr = 1'b0;
    s_nxt.rd = 1'b0;
    // two-flop synchronisers, oversampled far above 1 MHz
    s_nxt.scl1 = sclk_in;
    s_nxt.scl2 = s_r.scl1;
    s_nxt.scl3 = s_r.scl2;
    s_nxt.sda1 = sda_mosi_in;
    s_nxt.sda2 = s_r.sda1;
    s_nxt.sda3 = s_r.sda2;
    s_nxt.cs1 = chip_select_low_in;
    s_nxt.cs2 = s_r.cs1;
    s_nxt.ma1 = miso_addr_in;
    s_nxt.ma2 = s_r.ma1;
    // catch straps once the synchronisers have settled
    if (!s_r.strap_done)
    begin
      s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
      if (s_r.strap_cnt == `GSH_STRAP_WAIT)
      begin
        s_nxt.strap_done = 1'b1;
        s_nxt.addr_lsb = s_r.ma2;
        s_nxt.first_life = first_life_in;
      end
    end
    // uptime counter, saturating
    if (s_r.up != '1)
    begin
      s_nxt.up = s_r.up + `GSH_UP_W'(1);
    end
    // validity code, worst condition first
    if (signals_bad_in)
    begin
      s_nxt.validity = `GSH_VAL_BAD;
    end
    else if (s_r.first_life && s_r.up < STARTUP_CYC)
    begin
      s_nxt.validity = `GSH_VAL_START;
    end
    else if (s_r.up < WARMUP_CYC)
    begin
      s_nxt.validity = `GSH_VAL_WARM;
    end
    else
    begin
      s_nxt.validity = `GSH_VAL_OK;
    end
    s_nxt.start_done = s_r.first_life && s_r.up >= STARTUP_CYC;
    // sticky mode selection
    if (s_r.strap_done && !s_r.cs2)
    begin
      s_nxt.spi_mode = 1'b1;
    end
    s_nxt.miso_oe = spi & ~s_r.cs2;
    if (!s_r.strap_done)
    begin
      s_nxt.state = gsh_pkg::S_IDLE;
    end
    else if (spi)
    begin
      // spi slave, i2c traffic ignored
      s_nxt.sda_oe = 1'b0;
      // frame end, or first spi cycle: drop any i2c bit count left over
      if (s_r.cs2 || !s_r.spi_mode)
      begin
        s_nxt.state = gsh_pkg::S_IDLE;
        s_nxt.cnt = 4'h0;
      end
      else if (rise)
      begin
        s_nxt.shreg = inb;
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.cnt == `GSH_BYTE_BITS - 4'h1)
        begin
          s_nxt.cnt = 4'h0;
          case (s_r.state)
            gsh_pkg::S_SWR:
            begin
              s_nxt.addr = s_r.ptr;
              s_nxt.wdata = inb;
              s_nxt.wr = 1'b1;
              s_nxt.ptr = s_r.ptr + 8'h01;
            end
            gsh_pkg::S_SRD:
            begin
              s_nxt.rd = 1'b1;
              s_nxt.addr = s_r.ptr;
            end
            default:
            begin
              // command byte: register address and direction
              s_nxt.ptr = {1'b0, inb[7:1]};
              if (inb[0])
              begin
                s_nxt.state = gsh_pkg::S_SRD;
                s_nxt.rd = 1'b1;
                s_nxt.addr = {1'b0, inb[7:1]};
              end
              else
              begin
                s_nxt.state = gsh_pkg::S_SWR;
              end
            end
          endcase
        end
      end
      else if (fall && s_r.state == gsh_pkg::S_SRD && s_r.cnt != 4'h0)
      begin
        s_nxt.miso = s_r.obyte[7];
        s_nxt.obyte = {s_r.obyte[6:0], 1'b0};
      end
    end
    else if (start_c)
    begin
      // i2c slave, start or repeated start
      s_nxt.state = gsh_pkg::S_ADR;
      s_nxt.cnt = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      s_nxt.state = gsh_pkg::S_IDLE;
      s_nxt.sda_oe = 1'b0;
    end
    else if (rise)
    begin
      // sample on scl high
      case (s_r.state)
        gsh_pkg::S_ADR, gsh_pkg::S_REG, gsh_pkg::S_WDAT:
        begin
          s_nxt.shreg = inb;
          s_nxt.cnt = s_r.cnt + 4'h1;
        end
        gsh_pkg::S_RDAT:
        begin
          s_nxt.cnt = s_r.cnt + 4'h1;
        end
        gsh_pkg::S_MACK:
        begin
          s_nxt.more = ~s_r.sda2;
        end
        default:
        begin
          s_nxt.cnt = s_r.cnt;
        end
      endcase
    end
    else if (fall)
    begin
      // drive on scl low
      case (s_r.state)
        gsh_pkg::S_ADR:
        begin
          if (s_r.cnt == `GSH_BYTE_BITS)
          begin
            s_nxt.cnt = 4'h0;
            // own address only; general call, 10-bit ignored
            if (s_r.shreg[7:1] == my_addr)
            begin
              s_nxt.state = gsh_pkg::S_AACK;
              s_nxt.rw = s_r.shreg[0];
              s_nxt.sda_oe = 1'b1;
            end
            else
            begin
              s_nxt.state = gsh_pkg::S_IDLE;
            end
          end
        end
        gsh_pkg::S_REG:
        begin
          if (s_r.cnt == `GSH_BYTE_BITS)
          begin
            s_nxt.cnt = 4'h0;
            s_nxt.ptr = s_r.shreg;
            s_nxt.state = gsh_pkg::S_RACK;
            s_nxt.sda_oe = 1'b1;
          end
        end
        gsh_pkg::S_WDAT:
        begin
          if (s_r.cnt == `GSH_BYTE_BITS)
          begin
            s_nxt.cnt = 4'h0;
            s_nxt.addr = s_r.ptr;
            s_nxt.wdata = s_r.shreg;
            s_nxt.wr = 1'b1;
            s_nxt.ptr = s_r.ptr + 8'h01;
            s_nxt.state = gsh_pkg::S_WACK;
            s_nxt.sda_oe = 1'b1;
          end
        end
        gsh_pkg::S_AACK:
        begin
          s_nxt.sda_oe = 1'b0;
          if (s_r.rw)
          begin
            s_nxt.state = gsh_pkg::S_RDAT;
            s_nxt.rd = 1'b1;
            s_nxt.addr = s_r.ptr;
          end
          else
          begin
            s_nxt.state = gsh_pkg::S_REG;
          end
        end
        gsh_pkg::S_RACK, gsh_pkg::S_WACK:
        begin
          s_nxt.sda_oe = 1'b0;
          s_nxt.state = gsh_pkg::S_WDAT;
        end
        gsh_pkg::S_RDAT:
        begin
          if (s_r.cnt == `GSH_BYTE_BITS)
          begin
            s_nxt.cnt = 4'h0;
            s_nxt.sda_oe = 1'b0;
            s_nxt.state = gsh_pkg::S_MACK;
          end
          else
          begin
            s_nxt.sda_oe = ~s_r.obyte[7];
            s_nxt.obyte = {s_r.obyte[6:0], 1'b0};
          end
        end
        gsh_pkg::S_MACK:
        begin
          if (s_r.more)
          begin
            s_nxt.state = gsh_pkg::S_RDAT;
            s_nxt.rd = 1'b1;
            s_nxt.addr = s_r.ptr;
          end
          else
          begin
            s_nxt.state = gsh_pkg::S_IDLE;
          end
        end
        default:
        begin
          s_nxt.sda_oe = 1'b0;
        end
      endcase
    end
    // read fetch completes: load byte, present msb, advance
    if (s_r.rd)
    begin
      s_nxt.obyte = {rsel[6:0], 1'b0};
      s_nxt.ptr = s_r.ptr + 8'h01;
      if (spi)
      begin
        s_nxt.miso = rsel[7];
      end
      else
      begin
        s_nxt.sda_oe = ~rsel[7];
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      s_r <= '0;
      s_r.scl1 <= 1'b1;
      s_r.scl2 <= 1'b1;
      s_r.scl3 <= 1'b1;
      s_r.sda1 <= 1'b1;
      s_r.sda2 <= 1'b1;
      s_r.sda3 <= 1'b1;
      s_r.cs1 <= 1'b1;
      s_r.cs2 <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state record
  assign sda_oe_out = s_r.sda_oe; // only pulls sda, no scl drive
  assign miso_out = s_r.miso;
  assign miso_oe_out = s_r.miso_oe;
  assign reg_addr_out = s_r.addr;
  assign reg_wdata_out = s_r.wdata;
  assign reg_wr_out = s_r.wr;
  assign reg_rd_out = s_r.rd;
  assign validity_out = s_r.validity;
  assign start_done_out = s_r.start_done;
  assign spi_mode_out = s_r.spi_mode;

  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_spi_sticky: assert property (s_r.spi_mode |=> s_r.spi_mode)
    else $error("spi mode dropped");
  chk_spi_sda_quiet: assert property (s_r.spi_mode |=> !s_r.sda_oe)
    else $error("sda driven in spi mode");
  chk_strap_lsb: assert property ($rose(s_r.strap_done) |-> s_r.addr_lsb == $past(s_r.ma2))
    else $error("address strap not taken");
  chk_own_addr: assert property (s_r.state == gsh_pkg::S_AACK |-> s_r.shreg[7:1] == my_addr)
    else $error("acked foreign address");
  chk_never_master: assert property (s_r.sda_oe |-> s_r.state inside
    {gsh_pkg::S_AACK, gsh_pkg::S_RACK, gsh_pkg::S_WACK, gsh_pkg::S_RDAT})
    else $error("sda driven outside slave slots");
  chk_wr_ptr_step: assert property (s_r.wr |-> s_r.ptr == s_r.addr + 8'h01)
    else $error("pointer not advanced on write");
  chk_rd_ptr_step: assert property (s_r.rd |=> s_r.ptr == $past(s_r.addr) + 8'h01)
    else $error("pointer not advanced on read");
  chk_bad_code: assert property (signals_bad_in |=> validity_out == `GSH_VAL_BAD)
    else $error("invalid code missing");
  chk_start_code: assert property (!signals_bad_in && s_r.first_life && s_r.up < STARTUP_CYC
    |=> validity_out == `GSH_VAL_START)
    else $error("start-up code missing");
  chk_warm_code: assert property (!signals_bad_in && !s_r.first_life && s_r.up < WARMUP_CYC
    |=> validity_out == `GSH_VAL_WARM)
    else $error("warm-up code missing");
  chk_ok_code: assert property (!signals_bad_in && s_r.up >= STARTUP_CYC
    |=> validity_out == `GSH_VAL_OK)
    else $error("ok code missing");

  cov_i2c_write: cover property (!s_r.spi_mode && s_r.wr);
  cov_i2c_read: cover property (s_r.state == gsh_pkg::S_MACK && s_r.more);
  cov_spi_read: cover property (s_r.spi_mode && s_r.rd);
  cov_start_up: cover property (validity_out == `GSH_VAL_START);

endmodule : gsh_host_if

/* File: design/gsh_params.svh */
/*
  constants of the gas sensor host interface: addresses, codes, timings.
  assumes a 50 MHz system clock and the includer owning the scope.
*/
// Behaviour
// - chip select high: act as I2C slave
// - strap pin at power-up sets address LSB
// - chip select low: SPI until power-on reset
// - one register map for both interfaces
// - I2C works up to 1 Mbit/s
// - detect START/STOP, acknowledge own 7-bit address
// - ignore 10-bit, general call, reset, ID
// - never master, no arbitration or sync
// - pointer advances after each data byte
// - code 1 first minute, else 0
// - code 2 first hour of lifetime
// - code 3 when outputs implausible
// - SPI samples rising edge, MSB first
`ifndef GSH_PARAMS_SVH
`define GSH_PARAMS_SVH
`define GSH_ADDR_HI 6'h29
`define GSH_STATUS_ADDR 8'h20
`define GSH_CLK_HZ 50000000
`define GSH_I2C_MAX_HZ 1000000
`define GSH_WARMUP_S 60
`define GSH_STARTUP_S 3600
`define GSH_UP_W 38
`define GSH_STRAP_WAIT 2'h2
`define GSH_BYTE_BITS 4'h8
`define GSH_VAL_OK 2'h0
`define GSH_VAL_WARM 2'h1
`define GSH_VAL_START 2'h2
`define GSH_VAL_BAD 2'h3
`endif

/* File: design/gsh_pkg.sv */
/*
  types of the gas sensor host interface: states and the state record.
  assumes gsh_params.svh on the include path.
*/
`include "gsh_params.svh"
package gsh_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_ADR = 4'h1,
    S_AACK = 4'h2,
    S_REG = 4'h3,
    S_RACK = 4'h4,
    S_WDAT = 4'h5,
    S_WACK = 4'h6,
    S_RDAT = 4'h7,
    S_MACK = 4'h8,
    S_SWR = 4'h9,
    S_SRD = 4'ha
  } gsh_state_t;
  typedef struct packed {
    logic scl1, scl2, scl3;
    logic sda1, sda2, sda3;
    logic cs1, cs2;
    logic ma1, ma2;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic addr_lsb;
    logic first_life;
    logic spi_mode;
    gsh_state_t state;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] obyte;
    logic rw;
    logic more;
    logic [7:0] ptr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic sda_oe;
    logic miso;
    logic miso_oe;
    logic [`GSH_UP_W-1:0] up;
    logic [1:0] validity;
    logic start_done;
  } gsh_regs_t;
endpackage : gsh_pkg
